/* File: rtl/ppsg_pkg.sv */
// Package with constants for the logic-array power and select gating block.
package ppsg_pkg;
    // Bit positions in power_mgmt_reg0.
    localparam int unsigned PMR0_SPEED_BIT    = 3;
    localparam int unsigned PMR0_CLK_BUS_BIT  = 4;
    localparam int unsigned PMR0_CLK_OMC_BIT  = 5;
    // Bit positions in power_mgmt_reg2.
    localparam int unsigned PMR2_RD_BIT       = 2;
    localparam int unsigned PMR2_WR_BIT       = 3;
    localparam int unsigned PMR2_PSEN_BIT     = 4;
    localparam int unsigned PMR2_ALE_BIT      = 5;
    localparam int unsigned PMR2_PC7_BIT      = 6;
    // Register reset values.
    localparam logic [7:0]  PMR0_RESET        = 8'h00;
    localparam logic [7:0]  PMR2_RESET        = 8'h00;
    // Quiet times before standby, in nanoseconds.
    localparam int unsigned QUIET_5V_NS       = 65;
    localparam int unsigned QUIET_3V3_NS      = 100;
    localparam int unsigned CLK_PERIOD_NS     = 50;
    // Least times round up to whole cycles.
    localparam int unsigned QUIET_5V_CYC =
        (QUIET_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QUIET_3V3_CYC =
        (QUIET_3V3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QCNT_W            = 3;
    localparam int unsigned N_FLASH           = 8;
    localparam int unsigned N_BOOT            = 4;
    localparam int unsigned N_IN              = 6;
    localparam int unsigned PDC_W             = 16;
    typedef enum logic [0:0] {PPSG_ACTIVE, PPSG_STANDBY} ppsg_pwr_t;
endpackage

/* File: rtl/ppsg_inbus_if.sv */
// Interface carrying the gated logic-array input bus between modules.
`timescale 1ns/10ps
`default_nettype none
interface ppsg_inbus_if;
    logic [ppsg_pkg::N_IN-1:0] bus;
    logic                      fast;
    logic                      sel_3v3;
    logic                      standby;
    logic                      wake;
    modport src (output bus, output fast, output sel_3v3,
                 input standby, input wake);
    modport mon (input bus, input fast, input sel_3v3,
                 output standby, output wake);
endinterface
`default_nettype wire

/* File: rtl/ppsg_standby.sv */
// Standby tracker: watches input-bus transitions and quiet time.
`timescale 1ns/10ps
`default_nettype none
module ppsg_standby (
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    ppsg_inbus_if.mon   ib
);
    logic [ppsg_pkg::N_IN-1:0]   prev_r;
    logic [ppsg_pkg::QCNT_W-1:0] quiet_r;
    logic [ppsg_pkg::QCNT_W-1:0] limit;
    logic                        edge_seen;
    ppsg_pkg::ppsg_pwr_t         state_r;
    ppsg_pkg::ppsg_pwr_t         state_nxt;

    assign edge_seen = |(prev_r ^ ib.bus);
    assign limit = ib.sel_3v3 ? ppsg_pkg::QCNT_W'(ppsg_pkg::QUIET_3V3_CYC)
                              : ppsg_pkg::QCNT_W'(ppsg_pkg::QUIET_5V_CYC);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= '0;
        end else begin
            prev_r <= ib.bus;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet_r <= '0;
        end else if (edge_seen || ib.fast) begin
            quiet_r <= '0;
        end else if (quiet_r != limit) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ppsg_pkg::PPSG_ACTIVE: begin
                if (!ib.fast && !edge_seen && quiet_r == limit - 3'h1) begin
                    state_nxt = ppsg_pkg::PPSG_STANDBY;
                end
            end
            ppsg_pkg::PPSG_STANDBY: begin
                // Any edge on an unblocked input wakes the arrays.
                if (ib.fast || edge_seen) begin
                    state_nxt = ppsg_pkg::PPSG_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ppsg_pkg::PPSG_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ib.standby = (state_r == ppsg_pkg::PPSG_STANDBY);
    assign ib.wake    = (state_r == ppsg_pkg::PPSG_STANDBY) && edge_seen;
endmodule // ppsg_standby
`default_nettype wire

/* File: rtl/ppsg_top.sv */
// Power and select gating around the programmable logic arrays.
`timescale 1ns/10ps
`default_nettype none
module ppsg_top (
    input  wire logic                       CLK_I,
    input  wire logic                       ARST_N_I,
    input  wire logic                       CSI_EN_I,
    input  wire logic                       PORT_D_PIN2_I,
    input  wire logic                       SEL_3V3_I,
    input  wire logic                       REG0_WE_I,
    input  wire logic                       REG2_WE_I,
    input  wire logic [7:0]                 REG_WDATA_I,
    input  wire logic [ppsg_pkg::N_FLASH-1:0] FLASH_DEC_I,
    input  wire logic [ppsg_pkg::N_BOOT-1:0]  BOOT_DEC_I,
    input  wire logic                       SRAM_DEC_I,
    input  wire logic                       CTRL_DEC_I,
    input  wire logic                       RD_N_I,
    input  wire logic                       WR_N_I,
    input  wire logic                       PSEN_N_I,
    input  wire logic                       ALE_I,
    input  wire logic                       PORT_C_PIN7_I,
    input  wire logic                       PORT_D_PIN1_I,
    input  wire logic                       CLK_IN_EN_I,
    input  wire logic                       LOGIC_OUT_I,
    output logic [ppsg_pkg::N_FLASH-1:0]    MAIN_FLASH_SECTOR_SEL_O,
    output logic [ppsg_pkg::N_BOOT-1:0]     BOOT_FLASH_SECTOR_SEL_O,
    output logic                            SRAM_SEL_O,
    output logic                            CTRL_SEL_O,
    output logic                            MEM_RD_N_O,
    output logic                            MEM_WR_N_O,
    output logic                            MEM_PSEN_N_O,
    output logic                            MEM_ALE_O,
    output logic [ppsg_pkg::N_IN-1:0]       ARRAY_IN_BUS_O,
    output logic                            LOGIC_OUT_O,
    output logic                            OMC_CLK_EN_O,
    output logic                            APD_TICK_O,
    output logic [7:0]                      POWER_MGMT_REG0_O,
    output logic [7:0]                      POWER_MGMT_REG2_O,
    output logic                            STANDBY_O,
    output logic                            FAST_MODE_O
);
    // Two-flop synchronisers for the pin inputs.
    localparam int unsigned NPIN = 8;
    // Synchronisers come out of reset at each pin's idle level, so the
    // strobes and the clock edge detector see no false edge; ARRAY_IN_BUS_O and the standby prev_r reset to 0, so bits 0-2 change once.
    localparam logic [NPIN-1:0] PIN_IDLE = 8'hf0;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [7:0]      pmr0_r;
    logic [7:0]      pmr2_r;
    logic            cs_ok;
    logic            ck_prev_r;
    logic            ck_rise;
    logic            logic_out_r;
    logic [ppsg_pkg::N_IN-1:0] in_bus;
    ppsg_inbus_if    ib ();

    assign pin_raw = {PORT_D_PIN2_I, RD_N_I, WR_N_I, PSEN_N_I,
                      ALE_I, PORT_C_PIN7_I, PORT_D_PIN1_I, LOGIC_OUT_I};

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic psen_n_s;
    logic ale_s;
    logic pc7_s;
    logic ck_s;
    logic lout_s;
    assign {cs_n_s, rd_n_s, wr_n_s, psen_n_s,
            ale_s, pc7_s, ck_s, lout_s} = pin_s2_r;

    // Power management registers; bit 3 of reg0 clears to fast mode.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pmr0_r <= ppsg_pkg::PMR0_RESET;
        end else if (REG0_WE_I) begin
            pmr0_r <= REG_WDATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pmr2_r <= ppsg_pkg::PMR2_RESET;
        end else if (REG2_WE_I) begin
            pmr2_r <= REG_WDATA_I;
        end
    end

    // Without the configured select the memories are always enabled.
    assign cs_ok = !CSI_EN_I || !cs_n_s;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MAIN_FLASH_SECTOR_SEL_O <= '0;
            BOOT_FLASH_SECTOR_SEL_O <= '0;
            SRAM_SEL_O              <= 1'b0;
            CTRL_SEL_O              <= 1'b0;
        end else begin
            // With CSI_EN_I set, select high forces every gated select off.
            MAIN_FLASH_SECTOR_SEL_O <=
                FLASH_DEC_I & {ppsg_pkg::N_FLASH{cs_ok}};
            BOOT_FLASH_SECTOR_SEL_O <=
                BOOT_DEC_I & {ppsg_pkg::N_BOOT{cs_ok}};
            SRAM_SEL_O              <= SRAM_DEC_I & cs_ok;
            CTRL_SEL_O              <= CTRL_DEC_I & cs_ok;
        end
    end

    // Strobes go to the memories regardless of blocking bits.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MEM_RD_N_O   <= 1'b1;
            MEM_WR_N_O   <= 1'b1;
            MEM_PSEN_N_O <= 1'b1;
            MEM_ALE_O    <= 1'b0;
        end else begin
            MEM_RD_N_O   <= rd_n_s;
            MEM_WR_N_O   <= wr_n_s;
            MEM_PSEN_N_O <= psen_n_s;
            MEM_ALE_O    <= ale_s;
        end
    end

    // Blocked inputs are held at their idle level so they make no edges.
    always_comb begin
        in_bus    = '0;
        in_bus[0] = pmr2_r[ppsg_pkg::PMR2_RD_BIT]   ? 1'b1 : rd_n_s;
        in_bus[1] = pmr2_r[ppsg_pkg::PMR2_WR_BIT]   ? 1'b1 : wr_n_s;
        in_bus[2] = pmr2_r[ppsg_pkg::PMR2_PSEN_BIT] ? 1'b1 : psen_n_s;
        in_bus[3] = pmr2_r[ppsg_pkg::PMR2_ALE_BIT]  ? 1'b0 : ale_s;
        in_bus[4] = pmr2_r[ppsg_pkg::PMR2_PC7_BIT]  ? 1'b0 : pc7_s;
        in_bus[5] = (!CLK_IN_EN_I || pmr0_r[ppsg_pkg::PMR0_CLK_BUS_BIT])
                    ? 1'b0 : ck_s;
    end

    assign ib.bus     = in_bus;
    assign ib.fast    = !pmr0_r[ppsg_pkg::PMR0_SPEED_BIT];
    assign ib.sel_3v3 = SEL_3V3_I;

    ppsg_standby u_standby (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .ib       (ib)
    );

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ARRAY_IN_BUS_O <= '0;
            STANDBY_O      <= 1'b0;
            FAST_MODE_O    <= 1'b1;
        end else begin
            ARRAY_IN_BUS_O <= in_bus;
            STANDBY_O      <= ib.standby;
            FAST_MODE_O    <= ib.fast;
        end
    end

    // Logic output is latched in standby; chip select never touches it.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            logic_out_r <= 1'b0;
        end else if (!ib.standby || ib.wake) begin
            logic_out_r <= lout_s;
        end
    end

    assign LOGIC_OUT_O = logic_out_r;

    // Common clock edge detection for macrocells and counter tick.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ck_prev_r <= 1'b0;
        end else begin
            ck_prev_r <= ck_s;
        end
    end

    assign ck_rise = CLK_IN_EN_I && ck_s && !ck_prev_r;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            OMC_CLK_EN_O <= 1'b0;
            APD_TICK_O   <= 1'b0;
        end else begin
            OMC_CLK_EN_O <= ck_rise
                && !pmr0_r[ppsg_pkg::PMR0_CLK_OMC_BIT];
            APD_TICK_O   <= ck_rise;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            POWER_MGMT_REG0_O <= ppsg_pkg::PMR0_RESET;
            POWER_MGMT_REG2_O <= ppsg_pkg::PMR2_RESET;
        end else begin
            POWER_MGMT_REG0_O <= pmr0_r;
            POWER_MGMT_REG2_O <= pmr2_r;
        end
    end
endmodule // ppsg_top
`default_nettype wire

/* File: test/ppsg_host_model.sv */
// Host bus strobes and common clock pin model.
`timescale 1ns/10ps
`default_nettype none
module ppsg_host_model (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      rd_n_o,
    output logic      wr_n_o,
    output logic      psen_n_o,
    output logic      ale_o,
    output logic      clk_o
);
    logic [2:0] cnt_r = 3'h0;
    // Pins move after the falling edge, well clear of sampling.
    always @(negedge clk_i) begin
        if (run_i) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    // Stopped means idle strobes and a common clock that stands still.
    assign ale_o    = run_i && cnt_r[1:0] == 2'h0;
    assign psen_n_o = !(run_i && cnt_r[1:0] == 2'h1);
    assign rd_n_o   = !(run_i && cnt_r == 3'h2);
    assign wr_n_o   = !(run_i && cnt_r == 3'h6);
    assign clk_o    = run_i && cnt_r[0];
endmodule // ppsg_host_model
`default_nettype wire

/* File: test/ppsg_top_sva.sv */
// Port checker for the power and select gating block.
`timescale 1ns/10ps
`default_nettype none
module ppsg_top_sva (
    input wire logic       CLK_I,
    input wire logic       ARST_N_I,
    input wire logic       CSI_EN_I,
    input wire logic       PORT_D_PIN2_I,
    input wire logic       REG0_WE_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] FLASH_DEC_I,
    input wire logic [3:0] BOOT_DEC_I,
    input wire logic       SRAM_DEC_I,
    input wire logic       CTRL_DEC_I,
    input wire logic       RD_N_I,
    input wire logic       WR_N_I,
    input wire logic       PSEN_N_I,
    input wire logic       ALE_I,
    input wire logic [7:0] MAIN_FLASH_SECTOR_SEL_O,
    input wire logic [3:0] BOOT_FLASH_SECTOR_SEL_O,
    input wire logic       SRAM_SEL_O,
    input wire logic       CTRL_SEL_O,
    input wire logic       MEM_RD_N_O,
    input wire logic       MEM_WR_N_O,
    input wire logic       MEM_PSEN_N_O,
    input wire logic       MEM_ALE_O,
    input wire logic [5:0] ARRAY_IN_BUS_O,
    input wire logic       OMC_CLK_EN_O,
    input wire logic       APD_TICK_O,
    input wire logic [7:0] POWER_MGMT_REG0_O,
    input wire logic [7:0] POWER_MGMT_REG2_O,
    input wire logic       STANDBY_O,
    input wire logic       FAST_MODE_O
);
    wire [13:0] dec_w = {FLASH_DEC_I, BOOT_DEC_I, SRAM_DEC_I, CTRL_DEC_I};
    wire [13:0] sel_w = {MAIN_FLASH_SECTOR_SEL_O, BOOT_FLASH_SECTOR_SEL_O,
                         SRAM_SEL_O, CTRL_SEL_O};
    wire [3:0]  str_w = {RD_N_I, WR_N_I, PSEN_N_I, ALE_I};
    wire [3:0]  mem_w = {MEM_RD_N_O, MEM_WR_N_O, MEM_PSEN_N_O, MEM_ALE_O};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_cs_high_off:
        assert property ((CSI_EN_I && PORT_D_PIN2_I)[*4] |-> sel_w == 14'h0)
            else $error("select active with chip select high");
    a_cs_low_pass:
        assert property ((CSI_EN_I && !PORT_D_PIN2_I)[*4]
            |-> sel_w == $past(dec_w)) else $error("select decode lost");
    a_mem_direct:
        assert property ($past(ARST_N_I, 4) |-> mem_w == $past(str_w, 3))
            else $error("memory strobe not passed through");
    a_speed_reset:
        assert property ($rose(ARST_N_I) |-> FAST_MODE_O
            && POWER_MGMT_REG0_O == 8'h00) else $error("bad reset state");
    a_speed_write:
        assert property (REG0_WE_I |-> ##2 POWER_MGMT_REG0_O ==
            $past(REG_WDATA_I, 2) && FAST_MODE_O == !POWER_MGMT_REG0_O[3])
            else $error("speed write wrong");
    a_strobe_block:
        assert property ((POWER_MGMT_REG2_O[5:2] == 4'hf)[*4]
            |-> ARRAY_IN_BUS_O[3:0] == 4'h7) else $error("strobe leaked");
    a_omc_gate:
        assert property (OMC_CLK_EN_O && $stable(POWER_MGMT_REG0_O[5])
            |-> APD_TICK_O && !POWER_MGMT_REG0_O[5]) else $error("omc gate");
    a_standby_quiet:
        assert property ($rose(STANDBY_O) |-> !FAST_MODE_O
            && $stable(ARRAY_IN_BUS_O)) else $error("standby too early");
    a_wake_edge:
        assert property (STANDBY_O && $changed(ARRAY_IN_BUS_O)
            |-> ##[0:2] !STANDBY_O) else $error("no wake on input edge");
    cover property (STANDBY_O ##1 !STANDBY_O);
    cover property (APD_TICK_O && !OMC_CLK_EN_O);
    cover property ((CSI_EN_I && PORT_D_PIN2_I)[*4]);
endmodule // ppsg_top_sva
bind ppsg_top ppsg_top_sva u_sva (.*);
`default_nettype wire

/* File: test/tb_ppsg_top.sv */
// Self-checking bench for the power and select gating block.
`timescale 1ns/10ps
`default_nettype none
module tb_ppsg_top;
    logic CLK_I, ARST_N_I, CSI_EN_I, PORT_D_PIN2_I, SEL_3V3_I, REG0_WE_I;
    logic REG2_WE_I, SRAM_DEC_I, CTRL_DEC_I, RD_N_I, WR_N_I, PSEN_N_I, ALE_I;
    logic PORT_C_PIN7_I, PORT_D_PIN1_I, CLK_IN_EN_I, LOGIC_OUT_I, SRAM_SEL_O;
    logic CTRL_SEL_O, MEM_RD_N_O, MEM_WR_N_O, MEM_PSEN_N_O, MEM_ALE_O;
    logic LOGIC_OUT_O, OMC_CLK_EN_O, APD_TICK_O, STANDBY_O, FAST_MODE_O, run;
    logic [7:0]  REG_WDATA_I, FLASH_DEC_I, MAIN_FLASH_SECTOR_SEL_O;
    logic [7:0]  POWER_MGMT_REG0_O, POWER_MGMT_REG2_O;
    logic [3:0]  BOOT_DEC_I, BOOT_FLASH_SECTOR_SEL_O;
    logic [5:0]  ARRAY_IN_BUS_O, a, o;
    logic        w;
    logic [29:0] rows [5];
    int          bad_count, cmp_count;
    ppsg_top dut (.*);
    ppsg_host_model host (.clk_i(CLK_I), .run_i(run), .rd_n_o(RD_N_I),
        .wr_n_o(WR_N_I), .psen_n_o(PSEN_N_I), .ale_o(ALE_I),
        .clk_o(PORT_D_PIN1_I));
    task automatic chk(input string nm, input logic [13:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input bit r2, input logic [7:0] d);
        @(negedge CLK_I);
        {REG0_WE_I, REG2_WE_I, REG_WDATA_I} = {!r2, r2, d};
        @(negedge CLK_I);
        {REG0_WE_I, REG2_WE_I} = 2'h0;
        repeat (4) @(negedge CLK_I);
    endtask
    // Sixteen cycles give exactly eight common clock rises when running.
    task automatic watch();
        {w, a, o} = 13'h0;
        repeat (16) begin
            @(negedge CLK_I);
            w = w | !STANDBY_O;
            a = a + APD_TICK_O;
            o = o + OMC_CLK_EN_O;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        CLK_I = 1'h0;
        forever #25 CLK_I = ~CLK_I;
    end
    initial begin
        #150000;
        bad_count++;
        final_report();
    end
    initial begin
        {ARST_N_I, CSI_EN_I, PORT_D_PIN2_I, SEL_3V3_I} = 4'h0;
        {REG0_WE_I, REG2_WE_I, REG_WDATA_I} = 10'h0;
        {FLASH_DEC_I, BOOT_DEC_I, SRAM_DEC_I, CTRL_DEC_I} = 14'h0;
        {PORT_C_PIN7_I, LOGIC_OUT_I, CLK_IN_EN_I, run} = 4'h6;
        rows = '{{2'h1, 14'h2a5b, 14'h2a5b}, {2'h2, 14'h3fff, 14'h3fff},
                 {2'h3, 14'h3fff, 14'h0000}, {2'h3, 14'h0001, 14'h0000},
                 {2'h0, 14'h1000, 14'h1000}};
        repeat (12) @(negedge CLK_I);
        chk("rst", {FAST_MODE_O, STANDBY_O, MEM_RD_N_O, MEM_WR_N_O,
            MEM_PSEN_N_O, MEM_ALE_O, POWER_MGMT_REG0_O}, 14'h2e00);
        ARST_N_I = 1'h1;
        foreach (rows[i]) begin
            @(negedge CLK_I);
            {CSI_EN_I, PORT_D_PIN2_I, FLASH_DEC_I, BOOT_DEC_I, SRAM_DEC_I,
                CTRL_DEC_I} = rows[i][29:14];
            repeat (5) @(negedge CLK_I);
            chk("sel", {MAIN_FLASH_SECTOR_SEL_O, BOOT_FLASH_SECTOR_SEL_O,
                SRAM_SEL_O, CTRL_SEL_O}, rows[i][13:0]);
            chk("lout", LOGIC_OUT_O, 14'h1);
        end
        wr(0, 8'h08);
        chk("fast", {FAST_MODE_O, STANDBY_O}, 14'h1);
        LOGIC_OUT_I = 1'h0;
        repeat (4) @(negedge CLK_I);
        chk("latch", LOGIC_OUT_O, 14'h1);
        PORT_C_PIN7_I = 1'h1;
        watch();
        chk("wake", {w, LOGIC_OUT_O}, 14'h2);
        wr(1, 8'h40);
        PORT_C_PIN7_I = 1'h0;
        watch();
        chk("pc7", w, 14'h0);
        wr(1, 8'h7c);
        wr(0, 8'h18);
        run = 1'h1;
        // Let the pin clock fill the synchronisers before counting rises.
        repeat (4) @(negedge CLK_I);
        watch();
        chk("common_clk_in", {w, a, o}, {1'h0, 6'h08, 6'h08});
        wr(0, 8'h38);
        watch();
        chk("omc", {w, a, o}, {1'h0, 6'h08, 6'h00});
        // The host unblocks the strobes before talking to a peripheral.
        wr(1, 8'h00);
        watch();
        chk("unblk", {w, a, o}, {1'h1, 6'h08, 6'h00});
        wr(0, 8'h00);
        chk("fast2", FAST_MODE_O, 14'h1);
        ARST_N_I = 1'h0;
        @(negedge CLK_I);
        chk("rst2", {FAST_MODE_O, STANDBY_O, MEM_RD_N_O, MEM_WR_N_O,
            MEM_PSEN_N_O, MEM_ALE_O, POWER_MGMT_REG2_O}, 14'h2e00);
        final_report();
    end
endmodule // tb_ppsg_top
`default_nettype wire
